// File: core/rse_pkg.sv
/*
  rse_pkg: constants, register map and carrier types for the rotate and sleep
  execution block.
  assumes: one clock domain, a classic Wishbone master with 32-bit data.
*/
package rse_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int RSE_ADR_W = 12;
  localparam int RSE_DATA_W = 8;
  localparam int RSE_FILE_AW = 7;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] RSE_OFS_INSTR = 12'h000;
  localparam logic [11:0] RSE_OFS_ACC = 12'h004;
  localparam logic [11:0] RSE_OFS_STATUS = 12'h008;
  localparam logic [11:0] RSE_OFS_WDOG = 12'h00C;
  localparam logic [2:0] RSE_FILE_WIN = 3'h1;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RSE_INSTR_OP_LSB = 0;
  localparam int RSE_INSTR_DEST_BIT = 2;
  localparam int RSE_INSTR_FADDR_LSB = 8;
  localparam int RSE_ST_CARRY = 0;
  localparam int RSE_ST_DC = 1;
  localparam int RSE_ST_ZERO = 2;
  localparam int RSE_ST_PD = 3;
  localparam int RSE_ST_TO = 4;
  localparam int RSE_ST_SLEEP = 5;
  localparam int RSE_WDOG_PRESC_LSB = 8;

  // ---------------------------------------------------------------
  // reset and clear values
  // ---------------------------------------------------------------
  localparam logic [7:0] RSE_ACC_RST = 8'h00;
  localparam logic RSE_PD_RST = 1'b1;
  localparam logic RSE_TO_RST = 1'b1;
  localparam logic [7:0] RSE_WDOG_CLEAR = 8'h00;
  localparam logic [7:0] RSE_PRESC_CLEAR = 8'h00;
  localparam logic [7:0] RSE_PRESC_LAST = 8'hFF;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RSE_OP_NONE,
    RSE_OP_RL,
    RSE_OP_RR,
    RSE_OP_SLEEP
  } rse_op_t;

  typedef enum logic {
    RSE_S_IDLE,
    RSE_S_WAIT
  } rse_fsm_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } rse_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rse_wb_rsp_t;

  typedef struct packed {
    rse_fsm_t fsm;
    rse_wb_rsp_t rsp;
    logic [7:0] acc;
    logic carry;
    logic dc;
    logic zero;
    logic pd_n;
    logic to_n;
    logic sleeping;
    logic osc_run;
    logic [7:0] wdog;
    logic [7:0] presc;
    rse_op_t op;
    logic dest;
    logic is_rd;
    logic [6:0] faddr;
  } rse_state_t;

endpackage : rse_pkg

// File: core/rse_file_mem.sv
/*
  rse_file_mem: single-port file register array, registered read data.
  assumes: read data valid one clock after the address is presented.
*/
module rse_file_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk_sys,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : rse_file_mem

// File: core/rse_exec.sv
/*
  rse_exec: rotate-through-carry and sleep execution with a Wishbone register port.
  assumes: classic Wishbone master, synchronous inputs, wake_req from outside.
*/
// Notes on behaviour
// - rotate left: carry into bit0, bit7 out
// - dest 0: result to accumulator, file unchanged
// - rotate right: carry into bit7, bit0 out
// - dest 1: result written back to file
// - sleep clears watchdog counter and prescaler
// - sleep clears powerdown flag, sets expiry flag
// - sleep halts oscillator, no execution until wake
module rse_exec
  import rse_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire rse_wb_req_t wb_req,
  output rse_wb_rsp_t wb_rsp,
  input wire logic wake_req,
  output logic osc_run,
  output logic sleeping
);

  // ---------------------------------------------------------------
  // state and memory port
  // ---------------------------------------------------------------
  rse_state_t st;
  rse_state_t next_st;
  logic [6:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic req_new;
  logic is_file;
  logic [6:0] file_idx;
  rse_op_t wr_op;
  logic [7:0] rot_res;
  logic rot_c;

  rse_file_mem #(
    .AW(RSE_FILE_AW),
    .DW(RSE_DATA_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign req_new = wb_req.cyc & wb_req.stb & ~st.rsp.ack;
  assign is_file = (wb_req.adr[11:9] == RSE_FILE_WIN);
  assign file_idx = wb_req.adr[8:2];
  assign wr_op = rse_op_t'(wb_req.dat[RSE_INSTR_OP_LSB +: 2]);

  // ---------------------------------------------------------------
  // rotate datapath
  // ---------------------------------------------------------------
  always_comb begin
    if (st.op == RSE_OP_RL) begin
      rot_res = {mem_rdata[6:0], st.carry};
      rot_c = mem_rdata[7];
    end else begin
      rot_res = {st.carry, mem_rdata[7:1]};
      rot_c = mem_rdata[0];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rsp.ack = 1'b0;
    mem_addr = st.faddr;
    mem_we = 1'b0;
    mem_wdata = rot_res;
    if (!st.sleeping) begin
      next_st.presc = st.presc + 8'h01;
      if (st.presc == RSE_PRESC_LAST) begin
        next_st.wdog = st.wdog + 8'h01;
      end
    end else if (wake_req) begin
      next_st.sleeping = 1'b0;
      next_st.osc_run = 1'b1;
    end
    unique case (st.fsm)
      RSE_S_IDLE: begin
        if (req_new) begin
          next_st.rsp.ack = 1'b1;
          next_st.rsp.dat = 32'h0000_0000;
          if (is_file) begin
            mem_addr = file_idx;
            if (wb_req.we) begin
              mem_we = wb_req.sel[0];
              mem_wdata = wb_req.dat[7:0];
            end else begin
              next_st.rsp.ack = 1'b0;
              next_st.faddr = file_idx;
              next_st.is_rd = 1'b1;
              next_st.fsm = RSE_S_WAIT;
            end
          end else if (wb_req.adr == RSE_OFS_INSTR) begin
            if (!wb_req.we) begin
              next_st.rsp.dat[RSE_INSTR_OP_LSB +: 2] = st.op;
              next_st.rsp.dat[RSE_INSTR_DEST_BIT] = st.dest;
              next_st.rsp.dat[RSE_INSTR_FADDR_LSB +: 7] = st.faddr;
            end else if (wb_req.sel[1:0] == 2'h3 && !st.sleeping) begin
              next_st.op = wr_op;
              next_st.dest = wb_req.dat[RSE_INSTR_DEST_BIT];
              next_st.faddr = wb_req.dat[RSE_INSTR_FADDR_LSB +: 7];
              if (wr_op == RSE_OP_RL || wr_op == RSE_OP_RR) begin
                mem_addr = wb_req.dat[RSE_INSTR_FADDR_LSB +: 7];
                next_st.rsp.ack = 1'b0;
                next_st.is_rd = 1'b0;
                next_st.fsm = RSE_S_WAIT;
              end else if (wr_op == RSE_OP_SLEEP) begin
                next_st.wdog = RSE_WDOG_CLEAR;
                next_st.presc = RSE_PRESC_CLEAR;
                next_st.pd_n = 1'b0;
                next_st.to_n = 1'b1;
                next_st.sleeping = 1'b1;
                next_st.osc_run = 1'b0;
              end
            end
          end else if (wb_req.adr == RSE_OFS_ACC) begin
            next_st.rsp.dat[7:0] = st.acc;
            if (wb_req.we && wb_req.sel[0]) begin
              next_st.acc = wb_req.dat[7:0];
            end
          end else if (wb_req.adr == RSE_OFS_STATUS) begin
            next_st.rsp.dat[RSE_ST_CARRY] = st.carry;
            next_st.rsp.dat[RSE_ST_DC] = st.dc;
            next_st.rsp.dat[RSE_ST_ZERO] = st.zero;
            next_st.rsp.dat[RSE_ST_PD] = st.pd_n;
            next_st.rsp.dat[RSE_ST_TO] = st.to_n;
            next_st.rsp.dat[RSE_ST_SLEEP] = st.sleeping;
            if (wb_req.we && wb_req.sel[0]) begin
              next_st.carry = wb_req.dat[RSE_ST_CARRY];
              next_st.dc = wb_req.dat[RSE_ST_DC];
              next_st.zero = wb_req.dat[RSE_ST_ZERO];
            end
          end else if (wb_req.adr == RSE_OFS_WDOG) begin
            next_st.rsp.dat[7:0] = st.wdog;
            next_st.rsp.dat[RSE_WDOG_PRESC_LSB +: 8] = st.presc;
          end
        end
      end
      RSE_S_WAIT: begin
        next_st.rsp.ack = 1'b1;
        next_st.fsm = RSE_S_IDLE;
        if (st.is_rd) begin
          next_st.rsp.dat = {24'h00_0000, mem_rdata};
        end else begin
          next_st.carry = rot_c;
          if (st.dest) begin
            mem_we = 1'b1;
          end else begin
            next_st.acc = rot_res;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st <= '0;
      st.fsm <= RSE_S_IDLE;
      st.acc <= RSE_ACC_RST;
      st.pd_n <= RSE_PD_RST;
      st.to_n <= RSE_TO_RST;
      st.osc_run <= 1'b1;
      st.op <= RSE_OP_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign wb_rsp = st.rsp;
  assign osc_run = st.osc_run;
  assign sleeping = st.sleeping;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic rot_exec;
  logic rot_take;
  logic sleep_take;
  assign rot_exec = (st.fsm == RSE_S_WAIT) && !st.is_rd;
  assign rot_take = req_new && (st.fsm == RSE_S_IDLE) && !is_file && wb_req.we
    && (wb_req.adr == RSE_OFS_INSTR) && (wb_req.sel[1:0] == 2'h3) && !st.sleeping
    && (wr_op == RSE_OP_RL || wr_op == RSE_OP_RR);
  assign sleep_take = req_new && (st.fsm == RSE_S_IDLE) && !is_file && wb_req.we
    && (wb_req.adr == RSE_OFS_INSTR) && (wb_req.sel[1:0] == 2'h3) && !st.sleeping
    && (wr_op == RSE_OP_SLEEP);

  chk_rotl_to_acc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.op == RSE_OP_RL && !st.dest |=>
    st.acc == {$past(mem_rdata[6:0]), $past(st.carry)} && st.carry == $past(mem_rdata[7]))
    else $error("rotate left result or carry wrong");

  chk_rotr_to_acc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.op == RSE_OP_RR && !st.dest |=>
    st.acc == {$past(st.carry), $past(mem_rdata[7:1])} && st.carry == $past(mem_rdata[0]))
    else $error("rotate right result or carry wrong");

  chk_dest_acc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && !st.dest |-> !mem_we)
    else $error("file written although destination is accumulator");

  chk_dest_file: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.dest |-> mem_we && mem_addr == st.faddr ##1 st.acc == $past(st.acc))
    else $error("file write-back missing or accumulator changed");

  chk_sleep_wdog: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sleep_take |=> st.wdog == RSE_WDOG_CLEAR && st.presc == RSE_PRESC_CLEAR)
    else $error("watchdog not cleared by sleep");

  chk_sleep_flags: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sleep_take |=> !st.pd_n && st.to_n)
    else $error("status flags wrong after sleep");

  chk_sleep_halt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st.sleeping |-> !st.osc_run && !rot_take
    ##1 (!st.sleeping || ($stable(st.wdog) && $stable(st.presc))))
    else $error("activity while sleeping");

  chk_rot_flags: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_take |=> rot_exec ##1 st.rsp.ack && $stable(st.zero) && $stable(st.dc))
    else $error("rotate timing or flags wrong");

  chk_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st.rsp.ack |=> !st.rsp.ack)
    else $error("ack held longer than one cycle");

  chk_file_rd_lat: assert property (@(posedge clk_sys) disable iff (!rst_b)
    req_new && st.fsm == RSE_S_IDLE && is_file && !wb_req.we |=> !st.rsp.ack ##1 st.rsp.ack)
    else $error("file read answer not two cycles after request");

  chk_reg_ack_lat: assert property (@(posedge clk_sys) disable iff (!rst_b)
    req_new && st.fsm == RSE_S_IDLE && !is_file && !rot_take |=> st.rsp.ack)
    else $error("register access not answered in one cycle");

  chk_rotl_file_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.dest && st.op == RSE_OP_RL |-> mem_we && mem_wdata == {mem_rdata[6:0], st.carry})
    else $error("rotate left write-back data wrong");

  chk_rotr_file_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.dest && st.op == RSE_OP_RR |-> mem_we && mem_wdata == {st.carry, mem_rdata[7:1]})
    else $error("rotate right write-back data wrong");

  chk_file_carry: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.dest |=>
    st.carry == (($past(st.op) == RSE_OP_RL) ? $past(mem_rdata[7]) : $past(mem_rdata[0])))
    else $error("carry wrong after rotate to file");

  // ---------------------------------------------------------------
  // checks: sleep and watchdog
  // ---------------------------------------------------------------

  chk_sleep_osc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sleep_take |=> st.sleeping && !st.osc_run)
    else $error("sleep did not halt the oscillator");

  chk_osc_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st.osc_run == !st.sleeping)
    else $error("oscillator state disagrees with sleep state");

  chk_sleep_no_exec: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st.sleeping |-> !rot_exec)
    else $error("rotate executing while sleeping");

  chk_wake_resume: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st.sleeping && wake_req |=> !st.sleeping && st.osc_run)
    else $error("wake request did not restart the core");

  chk_instr_refused: assert property (@(posedge clk_sys) disable iff (!rst_b)
    req_new && st.fsm == RSE_S_IDLE && wb_req.we && wb_req.adr == RSE_OFS_INSTR && st.sleeping
    |=> $stable(st.op) && $stable(st.dest) && $stable(st.faddr))
    else $error("instruction accepted while sleeping");

  chk_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !sleep_take |=> $stable(st.pd_n) && $stable(st.to_n))
    else $error("powerdown or expiry flag changed without sleep");

  chk_wdog_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !st.sleeping && !sleep_take && st.presc == RSE_PRESC_LAST
    |=> st.wdog == $past(st.wdog) + 8'h01)
    else $error("watchdog counter did not step on prescaler wrap");

  cov_rotl_file: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.op == RSE_OP_RL && st.dest);
  cov_rotl_acc: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.op == RSE_OP_RL && !st.dest);
  cov_rotr_acc: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.op == RSE_OP_RR && !st.dest);
  cov_rotr_file: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rot_exec && st.op == RSE_OP_RR && st.dest);
  cov_sleep_wake: cover property (@(posedge clk_sys) disable iff (!rst_b)
    sleep_take ##[1:100] (st.sleeping && wake_req));

endmodule : rse_exec

// File: testbench/test_rse_exec.sv
/*
  test_rse_exec: self-checking bench for the rotate and sleep execution block.
  assumes: rse_pkg and rse_exec compiled first; one 250 MHz clock; classic wishbone.
*/
module test_rse_exec
  import rse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------
  logic clk_sys;
  logic rst_b;
  logic wake_req;
  logic osc_run;
  logic sleeping;
  rse_wb_req_t wb_req;
  rse_wb_rsp_t wb_rsp;
  int errors = 0;
  int cmp_count = 0;

  rse_exec dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .wake_req(wake_req),
    .osc_run(osc_run),
    .sleeping(sleeping)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  // one classic cycle: hold until ack is sampled, then release
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    chk1("ack", 1'b1, wb_rsp.ack);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask : bus

  function automatic logic [8:0] rot(input logic [1:0] opc, input logic [7:0] v, input logic c);
    if (opc == 2'h1) begin
      return {v[7], v[6:0], c};
    end
    return {v[0], c, v[7:1]};
  endfunction : rot

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [1:0] opc;
    logic dest;
    logic cin;
    logic [6:0] fa;
    logic [7:0] fv;
    logic [7:0] acc0;
    logic [1:0] zd;
    logic [8:0] res;
    logic [11:0] fadr;
    rst_b <= 1'b0;
    wake_req <= 1'b0;
    wb_req <= '0;
    void'($urandom(8248));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk1("osc_run", 1'b1, osc_run);
    chk1("sleeping", 1'b0, sleeping);
    bus(1'b0, RSE_OFS_STATUS, 32'h0, rd);
    chk32("status", 32'h18, rd);
    // rotates: corners first, then random operands
    for (int i = 0; i < 24; i++) begin
      opc = i[0] ? 2'h2 : 2'h1;
      dest = i[1];
      fa = 7'($urandom);
      fv = (i < 4) ? (i[0] ? 8'h01 : 8'h80) : 8'($urandom);
      cin = (i < 4) ? i[1] : 1'($urandom);
      zd = 2'($urandom);
      acc0 = 8'($urandom);
      fadr = {RSE_FILE_WIN, fa, 2'b00};
      bus(1'b1, fadr, {24'h0, fv}, rd);
      bus(1'b1, RSE_OFS_STATUS, {29'h0, zd, cin}, rd);
      bus(1'b1, RSE_OFS_ACC, {24'h0, acc0}, rd);
      bus(1'b1, RSE_OFS_INSTR, {17'h0, fa, 5'h0, dest, opc}, rd);
      res = rot(opc, fv, cin);
      bus(1'b0, RSE_OFS_ACC, 32'h0, rd);
      chk32("acc", {24'h0, dest ? acc0 : res[7:0]}, rd);
      bus(1'b0, fadr, 32'h0, rd);
      chk32("file", {24'h0, dest ? res[7:0] : fv}, rd);
      bus(1'b0, RSE_OFS_STATUS, 32'h0, rd);
      chk32("status", {27'h3, zd, res[8]}, rd);
      if (!dest) begin
        acc0 = res[7:0];
      end
    end
    // sleep: watchdog must be running before it is cleared
    bus(1'b0, RSE_OFS_WDOG, 32'h0, rd);
    chk1("wdog running", 1'b1, rd[15:0] != 16'h0000);
    bus(1'b1, RSE_OFS_INSTR, 32'h3, rd);
    #1;
    chk1("sleeping", 1'b1, sleeping);
    chk1("osc_run", 1'b0, osc_run);
    bus(1'b0, RSE_OFS_STATUS, 32'h0, rd);
    chk32("status", {26'h0, 3'b110, zd, res[8]}, rd);
    bus(1'b0, RSE_OFS_WDOG, 32'h0, rd);
    chk32("wdog", 32'h0, rd);
    bus(1'b1, RSE_OFS_INSTR, {17'h0, fa, 5'h0, 1'b0, 2'h1}, rd);
    bus(1'b0, RSE_OFS_ACC, 32'h0, rd);
    chk32("acc", {24'h0, acc0}, rd);
    repeat (10) @(posedge clk_sys);
    bus(1'b0, RSE_OFS_WDOG, 32'h0, rd);
    chk32("wdog", 32'h0, rd);
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    #1;
    chk1("sleeping", 1'b0, sleeping);
    chk1("osc_run", 1'b1, osc_run);
    bus(1'b0, 12'h100, 32'h0, rd);
    chk32("unmapped", 32'h0, rd);
    report_and_stop();
  end

endmodule : test_rse_exec
